// [ethernet_dma_descriptor_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eth_dma_consts.svh"

// Summary of operation
// - Transmit descriptor address is upper pointer over current lower pointer bits 15..1.
// - Bit 0 of current descriptor pointers is the end-of-list flag.
// - No reset touches transmit or receive descriptor pointers.
// - Software reset changes nothing; hardware reset hits threshold, sequence and status flags.
// - Receive descriptor address joins upper pointer with current bits 15..1.
// - Threshold not above remaining words keeps next packet in same area.
// - Threshold above remaining words flags last packet and fetches next area.
// - Hardware reset loads threshold with 02F8h.
// - Resource accesses use resource upper over start, end, read or write.
// - Resource pointers store bits 15..1; bit 0 reads zero.
// - Read pointer is next descriptor read; write pointer next free slot.
// - Sequence register holds two modulo-256 counters: area high, packet low.
// - Packet counter increments after every received packet that does not move to the next area.
// - Next area clears packet counter and increments area counter.
// - Sequence register clears on hardware reset or software writing zero.
module ethernet_dma_descriptor_regs (
  input wire logic clk_sys_i,             // System clock, 20 MHz
  input wire logic reset_i,               // Hardware reset, async, active high
  input wire logic [3:0] address_i,       // Avalon word address
  input wire logic read_i,                // Avalon read
  input wire logic write_i,               // Avalon write
  input wire logic [31:0] writedata_i,    // Avalon write data
  input wire logic [3:0] byteenable_i,    // Avalon byte enables
  output logic [31:0] readdata_o,         // Avalon read data
  output logic waitrequest_o,             // Avalon wait request
  input wire logic pkt_done_i,            // End of packet reception, pulse
  input wire logic [15:0] remaining_i,    // Remaining buffer words
  input wire logic tx_low_load_i,         // DMA loads current transmit pointer
  input wire logic rx_low_load_i,         // DMA loads current receive pointer
  input wire logic res_read_load_i,       // DMA loads resource read pointer
  input wire logic [15:0] load_data_i,    // Value for the DMA loads
  output logic [31:0] tx_desc_addr_o,     // Transmit descriptor address
  output logic tx_end_o,                  // Transmit end of list
  output logic [31:0] rx_desc_addr_o,     // Receive descriptor address
  output logic rx_end_o,                  // Receive end of list
  output logic [31:0] res_start_addr_o,   // Resource area start address
  output logic [31:0] res_end_addr_o,     // Resource area end address
  output logic [31:0] res_read_addr_o,    // Next resource descriptor to read
  output logic [31:0] res_write_addr_o,   // Next free resource slot
  output logic res_ptr_equal_o,           // Read pointer equals write pointer
  output logic [15:0] rx_seq_o,           // Receive sequence counters
  output logic last_packet_o,             // Last packet in area, sticky
  output logic fetch_resource_o           // Fetch next resource, pulse
);

  localparam int RES_START = 0;
  localparam int RES_END = 1;
  localparam int RES_READ = 2;
  localparam int RES_WRITE = 3;

  reg_bus_if bus ();

  eth_dma_pkg::reg16_t tx_upper_ff;
  eth_dma_pkg::reg16_t tx_low_ff;
  eth_dma_pkg::reg16_t rx_upper_ff;
  eth_dma_pkg::reg16_t rx_low_ff;
  eth_dma_pkg::reg16_t threshold_ff;
  eth_dma_pkg::reg16_t res_upper_ff;
  eth_dma_pkg::ptr15_t res_ptr_ff [4];
  logic last_packet_ff;
  logic ptr_equal_ff;
  eth_dma_pkg::addr32_t tx_addr_ff;
  eth_dma_pkg::addr32_t rx_addr_ff;
  eth_dma_pkg::addr32_t res_addr_ff [4];
  logic tx_end_ff;
  logic rx_end_ff;
  eth_dma_pkg::reg16_t rx_seq;
  logic area_done;
  logic seq_wr;
  logic sts_wr;
  eth_dma_pkg::reg16_t nxt_wval;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic eth_dma_pkg::reg16_t merge_be(
    input eth_dma_pkg::reg16_t old_val,
    input eth_dma_pkg::reg16_t new_val,
    input logic [1:0] be
  );
    merge_be = {be[1] ? new_val[15:8] : old_val[15:8],
                be[0] ? new_val[7:0] : old_val[7:0]};
  endfunction

  function automatic eth_dma_pkg::addr32_t join_addr(
    input eth_dma_pkg::reg16_t upper,
    input eth_dma_pkg::ptr15_t low
  );
    join_addr = {upper, low, 1'b0};
  endfunction

  function automatic logic hit(input eth_dma_pkg::reg_idx_t idx);
    hit = bus.wr_stb && (bus.idx == idx);
  endfunction

  // ****************************************
  // Bus slave and sequence counters
  // ****************************************
  avmm_reg_slave u_slave (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .byteenable_i(byteenable_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .bus(bus.slave)
  );

  // Decoded here so the strobe is seen inside the function
  always_comb begin
    seq_wr = hit(`OFS_RX_SEQ);
    sts_wr = hit(`OFS_STATUS);
    nxt_wval = merge_be(rx_seq, bus.wdata, bus.be);
  end

  rx_seq_ctrl u_seq (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pkt_done_i(pkt_done_i),
    .remaining_i(remaining_i),
    .threshold_i(threshold_ff),
    .sw_wr_i(seq_wr),
    .sw_wdata_i(nxt_wval),
    .seq_o(rx_seq),
    .area_done_o(area_done)
  );

  // ****************************************
  // Descriptor pointers, kept through every reset
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (hit(`OFS_TX_UPPER)) begin
      tx_upper_ff <= merge_be(tx_upper_ff, bus.wdata, bus.be);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (tx_low_load_i) begin
      tx_low_ff <= load_data_i;
    end else if (hit(`OFS_TX_LOW)) begin
      tx_low_ff <= merge_be(tx_low_ff, bus.wdata, bus.be);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (hit(`OFS_RX_UPPER)) begin
      rx_upper_ff <= merge_be(rx_upper_ff, bus.wdata, bus.be);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rx_low_load_i) begin
      rx_low_ff <= load_data_i;
    end else if (hit(`OFS_RX_LOW)) begin
      rx_low_ff <= merge_be(rx_low_ff, bus.wdata, bus.be);
    end
  end

  // ****************************************
  // Resource area registers, kept through every reset
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (hit(`OFS_RES_UPPER)) begin
      res_upper_ff <= merge_be(res_upper_ff, bus.wdata, bus.be);
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_res_ptr
    eth_dma_pkg::reg16_t merged;
    assign merged = merge_be({res_ptr_ff[g], 1'b0}, bus.wdata, bus.be);
    always_ff @(posedge clk_sys_i) begin
      if (g == RES_READ && res_read_load_i) begin
        res_ptr_ff[g] <= load_data_i[15:1];
      end else if (hit(4'(`OFS_RES_START + g))) begin
        res_ptr_ff[g] <= merged[15:1];
      end
    end
  end

  // ****************************************
  // Threshold, reset only by hardware reset
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      threshold_ff <= `THRESHOLD_RST;
    end else if (hit(`OFS_THRESHOLD)) begin
      threshold_ff <= merge_be(threshold_ff, bus.wdata, bus.be);
    end
  end

  // ****************************************
  // Status: sticky last packet, write one to clear, set wins
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      last_packet_ff <= 1'b0;
    end else if (area_done) begin
      last_packet_ff <= 1'b1;
    end else if (sts_wr && bus.be[0] && bus.wdata[`STS_LAST_PKT_BIT]) begin
      last_packet_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_equal_ff <= 1'b0;
    end else begin
      ptr_equal_ff <= res_ptr_ff[RES_READ] == res_ptr_ff[RES_WRITE];
    end
  end

  // ****************************************
  // Address formation
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tx_addr_ff <= 32'h0000_0000;
      tx_end_ff <= 1'b0;
    end else begin
      tx_addr_ff <= join_addr(tx_upper_ff, tx_low_ff[15:1]);
      tx_end_ff <= tx_low_ff[`END_LIST_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rx_addr_ff <= 32'h0000_0000;
      rx_end_ff <= 1'b0;
    end else begin
      rx_addr_ff <= join_addr(rx_upper_ff, rx_low_ff[15:1]);
      rx_end_ff <= rx_low_ff[`END_LIST_BIT];
    end
  end

  for (genvar r = 0; r < 4; r++) begin : g_res_addr
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        res_addr_ff[r] <= 32'h0000_0000;
      end else begin
        res_addr_ff[r] <= join_addr(res_upper_ff, res_ptr_ff[r]);
      end
    end
  end

  // ****************************************
  // Read mux, unmapped reads zero
  // ****************************************
  always_comb begin
    unique case (bus.idx)
      `OFS_TX_UPPER: bus.rdata = tx_upper_ff;
      `OFS_TX_LOW: bus.rdata = tx_low_ff;
      `OFS_RX_UPPER: bus.rdata = rx_upper_ff;
      `OFS_RX_LOW: bus.rdata = rx_low_ff;
      `OFS_THRESHOLD: bus.rdata = threshold_ff;
      `OFS_RES_UPPER: bus.rdata = res_upper_ff;
      `OFS_RES_START: bus.rdata = {res_ptr_ff[RES_START], 1'b0};
      `OFS_RES_END: bus.rdata = {res_ptr_ff[RES_END], 1'b0};
      `OFS_RES_READ: bus.rdata = {res_ptr_ff[RES_READ], 1'b0};
      `OFS_RES_WRITE: bus.rdata = {res_ptr_ff[RES_WRITE], 1'b0};
      `OFS_RX_SEQ: bus.rdata = rx_seq;
      `OFS_STATUS: bus.rdata = {14'h0000, ptr_equal_ff, last_packet_ff};
      default: bus.rdata = 16'h0000;
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_desc_addr_o = tx_addr_ff;
  assign tx_end_o = tx_end_ff;
  assign rx_desc_addr_o = rx_addr_ff;
  assign rx_end_o = rx_end_ff;
  assign res_start_addr_o = res_addr_ff[RES_START];
  assign res_end_addr_o = res_addr_ff[RES_END];
  assign res_read_addr_o = res_addr_ff[RES_READ];
  assign res_write_addr_o = res_addr_ff[RES_WRITE];
  assign res_ptr_equal_o = ptr_equal_ff;
  assign rx_seq_o = rx_seq;
  assign last_packet_o = last_packet_ff;
  assign fetch_resource_o = area_done;

endmodule

`default_nettype wire

// [eth_dma_consts.svh]
`ifndef ETH_DMA_CONSTS_SVH
`define ETH_DMA_CONSTS_SVH

// ****************************************
// Register word indices (byte address = 4 * index)
// ****************************************
`define OFS_TX_UPPER 4'h0
`define OFS_TX_LOW 4'h1
`define OFS_RX_UPPER 4'h2
`define OFS_RX_LOW 4'h3
`define OFS_THRESHOLD 4'h4
`define OFS_RES_UPPER 4'h5
`define OFS_RES_START 4'h6
`define OFS_RES_END 4'h7
`define OFS_RES_READ 4'h8
`define OFS_RES_WRITE 4'h9
`define OFS_RX_SEQ 4'hA
`define OFS_STATUS 4'hB

// ****************************************
// Field positions
// ****************************************
`define END_LIST_BIT 0
`define SEQ_AREA_MSB 15
`define SEQ_AREA_LSB 8
`define SEQ_PKT_MSB 7
`define SEQ_PKT_LSB 0
`define STS_LAST_PKT_BIT 0
`define STS_PTR_EQ_BIT 1

// ****************************************
// Reset values
// ****************************************
`define THRESHOLD_RST 16'h02F8
`define RX_SEQ_RST 16'h0000
`define STATUS_RST 2'h0

`endif

// [eth_dma_pkg.sv]
package eth_dma_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [14:0] ptr15_t;
  typedef logic [31:0] addr32_t;
  typedef logic [3:0] reg_idx_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// [reg_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface reg_bus_if;
  logic wr_stb;
  eth_dma_pkg::reg_idx_t idx;
  eth_dma_pkg::reg16_t wdata;
  logic [1:0] be;
  eth_dma_pkg::reg16_t rdata;

  modport slave (output wr_stb, output idx, output wdata, output be, input rdata);
  modport regs (input wr_stb, input idx, input wdata, input be, output rdata);
endinterface

`default_nettype wire

// [avmm_reg_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module avmm_reg_slave (
  input wire logic clk_sys_i,          // System clock
  input wire logic reset_i,            // Async reset, active high
  input wire logic [3:0] address_i,    // Word address
  input wire logic read_i,             // Read request
  input wire logic write_i,            // Write request
  input wire logic [31:0] writedata_i, // Write data
  input wire logic [3:0] byteenable_i, // Byte enables
  output logic [31:0] readdata_o,      // Read data
  output logic waitrequest_o,          // Wait request
  reg_bus_if.slave bus                 // Register side
);

  eth_dma_pkg::bus_state_t state_ff;
  logic [31:0] readdata_ff;
  logic waitrequest_ff;

  assign bus.idx = address_i;
  assign bus.wdata = writedata_i[15:0];
  assign bus.be = byteenable_i[1:0];
  // Write commits only at the edge where waitrequest is seen low
  assign bus.wr_stb = (state_ff == eth_dma_pkg::BUS_ACK) && write_i;
  assign readdata_o = readdata_ff;
  assign waitrequest_o = waitrequest_ff;

  // ****************************************
  // Request handshake
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= eth_dma_pkg::BUS_IDLE;
      waitrequest_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        eth_dma_pkg::BUS_IDLE: begin
          if (read_i || write_i) begin
            state_ff <= eth_dma_pkg::BUS_ACK;
            waitrequest_ff <= 1'b0;
          end
        end
        eth_dma_pkg::BUS_ACK: begin
          state_ff <= eth_dma_pkg::BUS_IDLE;
          waitrequest_ff <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Read data, upper half reads zero
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      readdata_ff <= 32'h0000_0000;
    end else if (state_ff == eth_dma_pkg::BUS_IDLE && read_i) begin
      readdata_ff <= {16'h0000, bus.rdata};
    end
  end

endmodule

`default_nettype wire

// [rx_seq_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eth_dma_consts.svh"

module rx_seq_ctrl (
  input wire logic clk_sys_i,                   // System clock
  input wire logic reset_i,                     // Hardware reset
  input wire logic pkt_done_i,                  // Packet reception ended
  input wire eth_dma_pkg::reg16_t remaining_i,  // Words left in buffer area
  input wire eth_dma_pkg::reg16_t threshold_i,  // End-of-buffer threshold
  input wire logic sw_wr_i,                     // Software write of counters
  input wire eth_dma_pkg::reg16_t sw_wdata_i,   // Software write value
  output eth_dma_pkg::reg16_t seq_o,            // Sequence counters
  output logic area_done_o                      // Move to next area, pulse
);

  eth_dma_pkg::reg16_t seq_ff;
  logic area_done_ff;
  logic exhausted;

  assign exhausted = threshold_i > remaining_i;
  assign seq_o = seq_ff;
  assign area_done_o = area_done_ff;

  // ****************************************
  // Sequence counters
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      seq_ff <= `RX_SEQ_RST;
    end else if (pkt_done_i && exhausted) begin
      seq_ff[`SEQ_PKT_MSB:`SEQ_PKT_LSB] <= 8'h00;
      seq_ff[`SEQ_AREA_MSB:`SEQ_AREA_LSB] <=
        seq_ff[`SEQ_AREA_MSB:`SEQ_AREA_LSB] + 8'h01;
    end else if (pkt_done_i) begin
      seq_ff[`SEQ_PKT_MSB:`SEQ_PKT_LSB] <=
        seq_ff[`SEQ_PKT_MSB:`SEQ_PKT_LSB] + 8'h01;
    end else if (sw_wr_i) begin
      seq_ff <= sw_wdata_i;
    end
  end

  // ****************************************
  // Next area request
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      area_done_ff <= 1'b0;
    end else begin
      area_done_ff <= pkt_done_i && exhausted;
    end
  end

endmodule

`default_nettype wire

// [ethernet_dma_descriptor_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module ethernet_dma_descriptor_regs_monitor (
  input wire logic clk_sys_i,               // System clock
  input wire logic reset_i,                 // Hardware reset
  input wire logic read_i,                  // Avalon read
  input wire logic write_i,                 // Avalon write
  input wire logic [31:0] readdata_o,       // Avalon read data
  input wire logic waitrequest_o,           // Avalon wait request
  input wire logic pkt_done_i,              // End of packet
  input wire logic tx_low_load_i,           // Transmit pointer load
  input wire logic rx_low_load_i,           // Receive pointer load
  input wire logic res_read_load_i,         // Read pointer load
  input wire logic [15:0] load_data_i,      // Load value
  input wire logic [31:0] tx_desc_addr_o,   // Transmit address
  input wire logic tx_end_o,                // Transmit end of list
  input wire logic [31:0] rx_desc_addr_o,   // Receive address
  input wire logic rx_end_o,                // Receive end of list
  input wire logic [31:0] res_read_addr_o,  // Resource read address
  input wire logic [31:0] res_start_addr_o, // Resource start address
  input wire logic [15:0] rx_seq_o,         // Sequence counters
  input wire logic last_packet_o,           // Last packet flag
  input wire logic fetch_resource_o         // Fetch pulse
);
  // ****************************************
  // Sequences
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence area_moved;
    pkt_done_i ##1 (rx_seq_o[7:0] == 8'h00 && rx_seq_o[15:8] == $past(rx_seq_o[15:8]) + 8'h01);
  endsequence

  sequence area_kept;
    pkt_done_i ##1 (rx_seq_o[7:0] != 8'h00);
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  chk_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest did not drop after one cycle");
  chk_wait_short: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_upper_zero: assert property (readdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_addr_bit0: assert property (
    tx_desc_addr_o[0] == 1'b0 && rx_desc_addr_o[0] == 1'b0 && res_start_addr_o[0] == 1'b0)
    else $error("formed address bit 0 not low");
  chk_seq_step: assert property (pkt_done_i |=>
    (rx_seq_o[7:0] == $past(rx_seq_o[7:0]) + 8'h01 && rx_seq_o[15:8] == $past(rx_seq_o[15:8]))
    || (rx_seq_o[7:0] == 8'h00 && rx_seq_o[15:8] == $past(rx_seq_o[15:8]) + 8'h01))
    else $error("sequence counters stepped wrongly");
  chk_area_fetch: assert property (area_moved |-> fetch_resource_o ##1 last_packet_o)
    else $error("new area without fetch or flag");
  chk_area_kept: assert property (area_kept |-> !fetch_resource_o)
    else $error("fetch while staying in area");
  chk_fetch_cause: assert property (fetch_resource_o |-> $past(pkt_done_i))
    else $error("fetch without a packet");
  chk_tx_load: assert property (tx_low_load_i |-> ##2
    {tx_desc_addr_o[15:1], tx_end_o} == $past(load_data_i, 2))
    else $error("transmit load not reflected");
  chk_rx_load: assert property (rx_low_load_i |-> ##2
    {rx_desc_addr_o[15:1], rx_end_o} == $past(load_data_i, 2))
    else $error("receive load not reflected");
  chk_res_load: assert property (res_read_load_i |-> ##2
    res_read_addr_o[15:0] == ($past(load_data_i, 2) & 16'hFFFE))
    else $error("read pointer load not reflected");
endmodule

bind ethernet_dma_descriptor_regs ethernet_dma_descriptor_regs_monitor mon (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .pkt_done_i(pkt_done_i),
  .tx_low_load_i(tx_low_load_i), .rx_low_load_i(rx_low_load_i),
  .res_read_load_i(res_read_load_i), .load_data_i(load_data_i),
  .tx_desc_addr_o(tx_desc_addr_o), .tx_end_o(tx_end_o), .rx_desc_addr_o(rx_desc_addr_o),
  .rx_end_o(rx_end_o), .res_read_addr_o(res_read_addr_o), .res_start_addr_o(res_start_addr_o),
  .rx_seq_o(rx_seq_o), .last_packet_o(last_packet_o), .fetch_resource_o(fetch_resource_o));

`default_nettype wire

// [rx_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none

module rx_dma_model (
  input wire logic clk_sys_i,     // System clock
  output logic pkt_done_o,        // End of packet reception
  output logic [15:0] remaining_o, // Words left in the area
  output logic tx_low_load_o,     // Transmit pointer load
  output logic rx_low_load_o,     // Receive pointer load
  output logic res_read_load_o,   // Read pointer load
  output logic [15:0] load_data_o // Value for the loads
);
  initial begin
    pkt_done_o = 1'b0;
    remaining_o = 16'hFFFF;
    {res_read_load_o, rx_low_load_o, tx_low_load_o} = 3'h0;
    load_data_o = 16'h0000;
  end

  // Back-to-back packets, all leaving the same count
  task automatic packet(input logic [15:0] rem, input int n);
    @(posedge clk_sys_i);
    pkt_done_o <= 1'b1;
    remaining_o <= rem;
    repeat (n) @(posedge clk_sys_i);
    pkt_done_o <= 1'b0;
    remaining_o <= ~rem;
  endtask

  // Values keep bit 1 low and stay in one 32k-word area
  task automatic load(input logic [2:0] sel, input logic [15:0] v);
    @(posedge clk_sys_i);
    {res_read_load_o, rx_low_load_o, tx_low_load_o} <= sel;
    load_data_o <= v;
    @(posedge clk_sys_i);
    {res_read_load_o, rx_low_load_o, tx_low_load_o} <= 3'h0;
    load_data_o <= ~v;
  endtask
endmodule

`default_nettype wire

// [ethernet_dma_descriptor_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eth_dma_consts.svh"

module ethernet_dma_descriptor_regs_bench;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] address_i = 4'h0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] byteenable_i = 4'h0;
  logic [31:0] readdata_o, tx_desc_addr_o, rx_desc_addr_o, res_start_addr_o, res_end_addr_o;
  logic [31:0] res_read_addr_o, res_write_addr_o, q;
  logic waitrequest_o, tx_end_o, rx_end_o, res_ptr_equal_o, last_packet_o, fetch_resource_o;
  logic pkt_done_i, tx_low_load_i, rx_low_load_i, res_read_load_i;
  logic [15:0] remaining_i, load_data_i, rx_seq_o;
  int n_mismatch = 0;
  int n_tests = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  ethernet_dma_descriptor_regs dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .pkt_done_i(pkt_done_i), .remaining_i(remaining_i), .tx_low_load_i(tx_low_load_i),
    .rx_low_load_i(rx_low_load_i), .res_read_load_i(res_read_load_i),
    .load_data_i(load_data_i), .tx_desc_addr_o(tx_desc_addr_o), .tx_end_o(tx_end_o),
    .rx_desc_addr_o(rx_desc_addr_o), .rx_end_o(rx_end_o), .res_start_addr_o(res_start_addr_o),
    .res_end_addr_o(res_end_addr_o), .res_read_addr_o(res_read_addr_o),
    .res_write_addr_o(res_write_addr_o), .res_ptr_equal_o(res_ptr_equal_o),
    .rx_seq_o(rx_seq_o), .last_packet_o(last_packet_o), .fetch_resource_o(fetch_resource_o));

  rx_dma_model mdl (.clk_sys_i(clk_sys_i), .pkt_done_o(pkt_done_i), .remaining_o(remaining_i),
    .tx_low_load_o(tx_low_load_i), .rx_low_load_o(rx_low_load_i),
    .res_read_load_o(res_read_load_i), .load_data_o(load_data_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    address_i <= a;
    writedata_i <= {16'h0000, d};
    byteenable_i <= 4'h3;
    read_i <= !wr;
    write_i <= wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      check("waitrequest", 32'h0000_0000, {31'h0000_0000, waitrequest_o});
      summarize();
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 16'h0000);
    check(name, exp, q);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pkt(input logic [15:0] rem, input int n, input logic [15:0] seq, input logic f);
    mdl.packet(rem, n);
    #1;
    check("rx_seq", {16'h0000, seq}, {16'h0000, rx_seq_o});
    check("fetch", {31'h0000_0000, f}, {31'h0000_0000, fetch_resource_o});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    rd(`OFS_THRESHOLD, 32'h0000_02F8, "threshold");
    rd(`OFS_RX_SEQ, 32'h0000_0000, "sequence");
    xfer(1'b1, 4'hD, 16'hBEEF);
    rd(4'hD, 32'h0000_0000, "unmapped");
  endtask

  task automatic t_tx_rx;
    xfer(1'b1, `OFS_TX_UPPER, 16'hA5C3);
    xfer(1'b1, `OFS_TX_LOW, 16'h1235);
    xfer(1'b1, `OFS_RX_UPPER, 16'h5A3C);
    xfer(1'b1, `OFS_RX_LOW, 16'h8009);
    settle();
    check("tx_addr", 32'hA5C3_1234, tx_desc_addr_o);
    check("rx_addr", 32'h5A3C_8008, rx_desc_addr_o);
    check("list_end", 32'h0000_0003, {30'h0000_0000, tx_end_o, rx_end_o});
    rd(`OFS_TX_LOW, 32'h0000_1235, "tx_low");
    mdl.load(3'h1, 16'h4440);
    mdl.load(3'h2, 16'h0100);
    settle();
    check("tx_addr", 32'hA5C3_4440, tx_desc_addr_o);
    check("list_end", 32'h0000_0000, {30'h0000_0000, tx_end_o, rx_end_o});
  endtask

  task automatic t_resource;
    xfer(1'b1, `OFS_RES_UPPER, 16'h7E01);
    xfer(1'b1, `OFS_RES_START, 16'h2001);
    xfer(1'b1, `OFS_RES_END, 16'h3FFE);
    xfer(1'b1, `OFS_RES_READ, 16'h2100);
    xfer(1'b1, `OFS_RES_WRITE, 16'h2104);
    settle();
    rd(`OFS_RES_START, 32'h0000_2000, "res_start");
    check("start_addr", 32'h7E01_2000, res_start_addr_o);
    check("end_addr", 32'h7E01_3FFE, res_end_addr_o);
    check("write_addr", 32'h7E01_2104, res_write_addr_o);
    check("equal", 32'h0000_0000, {31'h0000_0000, res_ptr_equal_o});
    mdl.load(3'h4, 16'h2105);
    settle();
    check("read_addr", 32'h7E01_2104, res_read_addr_o);
    check("equal", 32'h0000_0001, {31'h0000_0000, res_ptr_equal_o});
  endtask

  task automatic t_areas;
    xfer(1'b1, `OFS_THRESHOLD, 16'h0040);
    xfer(1'b1, `OFS_RX_SEQ, 16'h12FE);
    pkt(16'h0040, 2, 16'h1200, 1'b0);
    pkt(16'h003F, 1, 16'h1300, 1'b1);
    rd(`OFS_STATUS, 32'h0000_0003, "status");
    xfer(1'b1, `OFS_STATUS, 16'h0001);
    settle();
    check("last_pkt", 32'h0000_0000, {31'h0000_0000, last_packet_o});
    xfer(1'b1, `OFS_RX_SEQ, 16'hFF05);
    pkt(16'h0000, 1, 16'h0000, 1'b1);
    xfer(1'b1, `OFS_RX_SEQ, 16'h0107);
    xfer(1'b1, `OFS_RX_SEQ, 16'h0000);
    rd(`OFS_RX_SEQ, 32'h0000_0000, "sequence");
    xfer(1'b1, `OFS_RX_SEQ, 16'h0107);
  endtask

  task automatic t_hw_reset;
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(`OFS_THRESHOLD, 32'h0000_02F8, "threshold");
    rd(`OFS_RX_SEQ, 32'h0000_0000, "sequence");
    rd(`OFS_RX_LOW, 32'h0000_0100, "rx_low");
    settle();
    check("tx_addr", 32'hA5C3_4440, tx_desc_addr_o);
    check("rx_addr", 32'h5A3C_0100, rx_desc_addr_o);
    check("start_addr", 32'h7E01_2000, res_start_addr_o);
    check("read_addr", 32'h7E01_2104, res_read_addr_o);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset_values();
    t_tx_rx();
    t_resource();
    t_areas();
    t_hw_reset();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    summarize();
  end
endmodule

`default_nettype wire
